// File: hdl/bud_regs.sv
`include "bud_cfg.svh"

// Functional notes
// - Twelve-bit field; bit n-1 turns on the balance switch between nodes n and n-1.
// - Upper reserved bits of the balance-switch register always read zero.
// - Loopback bit routes upper transmitter output into upper receiver.
// - Double-buffer select bit enables alternate double-buffer mode; default cleared.
// - Lower idle select makes lower transmit drivers idle high-Z, else drive zero.
// - Upper idle select makes upper transmit drivers idle high-Z, else drive zero.
// - Bit nine of device config stores and returns written value only.
// - Emergency-discharge enable bit starts emergency discharge mode.
// - Charge-pump disable bit turns off the HV charge pump.
// - Diagnostic bit thirteen mirrors the alternate-mux select bit.
// - Diagnostic bit twelve mirrors the polarity bit.
// - Cell mirror field writes update cell-measurement enables; reads return them.
// - During emergency discharge a four-bit counter runs at 2Hz and wraps.
module bud_regs import bud_pkg::*; #(
  parameter int unsigned DCHG_TICKS = `BUD_DCHG_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [11:0] balance_switch_enable,
  output logic upper_port_loopback,
  output logic alt_double_buffer_select,
  output logic lower_tx_idle_highz,
  output logic upper_tx_idle_highz,
  output logic emergency_discharge_enable,
  output logic hv_pump_disable,
  output logic [3:0] discharge_counter,
  input wire logic alt_mux_select,
  input wire logic polarity,
  input wire logic [11:0] cell_meas_enable,
  output logic cell_meas_enable_wr,
  output logic [11:0] cell_meas_enable_wdata,
  input wire logic lower_tx_data,
  input wire logic lower_tx_busy,
  output logic lower_tx_pin_out,
  output logic lower_tx_pin_oe,
  input wire logic upper_tx_data,
  input wire logic upper_tx_busy,
  output logic upper_tx_pin_out,
  output logic upper_tx_pin_oe,
  input wire logic upper_rx_pin_in,
  output logic upper_rx_data
);

  // The discharge prescaler needs at least two cycles per tick; refuse anything shorter at elaboration.
  if (DCHG_TICKS < 2) begin : g_bad_ticks
    $error("DCHG_TICKS must be at least 2");
  end

  // ==========================================================
  // Decode
  function automatic bud_sel_t decode_sel(input logic [31:0] a);
    bud_sel_t s;
    s = BUD_SEL_NONE;
    if (a[1:0] == 2'b00 && a[31:10] == 22'h00_0000) begin
      if (a[9:2] == `BUD_IDX_BAL) begin
        s = BUD_SEL_BAL;
      end else if (a[9:2] == `BUD_IDX_DEV) begin
        s = BUD_SEL_DEV;
      end else if (a[9:2] == `BUD_IDX_DIAG) begin
        s = BUD_SEL_DIAG;
      end
    end
    return s;
  endfunction : decode_sel

  logic addr_take;
  logic wr_pend;
  bud_sel_t wr_sel;
  logic wr_go;
  logic dev_rsvd9;
  logic fwd_cell;
  logic [11:0] next_bal;
  logic [15:0] next_dev;
  logic [11:0] next_cell;
  logic [15:0] rd_word;
  logic rx_s1;
  logic rx_s2;

  assign addr_take = hsel & htrans[1] & hready;
  assign wr_go = wr_pend & hready;

  // ==========================================================
  // Address phase capture
  // Only whole-word transfers are expected; hsize is not checked, every write updates all fields.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_sel <= BUD_SEL_NONE;
    end else if (ce && hready) begin
      wr_pend <= addr_take & hwrite;
      wr_sel <= addr_take ? decode_sel(haddr) : BUD_SEL_NONE;
    end
  end

  // ==========================================================
  // Write data phase and forwarded view
  // Reads use the value being written in the same cycle, so back-to-back write then read sees new data.
  always_comb begin
    next_bal = balance_switch_enable;
    next_dev = 16'h0000;
    next_dev[`BUD_DEV_LOOP] = upper_port_loopback;
    next_dev[`BUD_DEV_DBLBUF] = alt_double_buffer_select;
    next_dev[`BUD_DEV_LHIZ] = lower_tx_idle_highz;
    next_dev[`BUD_DEV_UHIZ] = upper_tx_idle_highz;
    next_dev[`BUD_DEV_RSVD9] = dev_rsvd9;
    next_dev[`BUD_DEV_EMG] = emergency_discharge_enable;
    next_dev[`BUD_DEV_HVCP] = hv_pump_disable;
    next_cell = fwd_cell ? cell_meas_enable_wdata : cell_meas_enable;
    if (wr_go && wr_sel == BUD_SEL_BAL) begin
      next_bal = hwdata[`BUD_BAL_EN_MSB:0];
    end
    if (wr_go && wr_sel == BUD_SEL_DEV) begin
      next_dev[`BUD_DEV_LOOP] = hwdata[`BUD_DEV_LOOP];
      next_dev[`BUD_DEV_DBLBUF] = hwdata[`BUD_DEV_DBLBUF];
      next_dev[`BUD_DEV_LHIZ] = hwdata[`BUD_DEV_LHIZ];
      next_dev[`BUD_DEV_UHIZ] = hwdata[`BUD_DEV_UHIZ];
      next_dev[`BUD_DEV_RSVD9] = hwdata[`BUD_DEV_RSVD9];
      next_dev[`BUD_DEV_EMG] = hwdata[`BUD_DEV_EMG];
      next_dev[`BUD_DEV_HVCP] = hwdata[`BUD_DEV_HVCP];
    end
    if (wr_go && wr_sel == BUD_SEL_DIAG) begin
      next_cell = hwdata[`BUD_DIAG_CELL_MSB:`BUD_DIAG_CELL_LSB];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      balance_switch_enable <= 12'h000;
    end else if (ce) begin
      balance_switch_enable <= next_bal;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_port_loopback <= 1'b0;
      alt_double_buffer_select <= 1'b0;
      lower_tx_idle_highz <= 1'b0;
      upper_tx_idle_highz <= 1'b0;
      dev_rsvd9 <= 1'b0;
      emergency_discharge_enable <= 1'b0;
      hv_pump_disable <= 1'b0;
    end else if (ce) begin
      upper_port_loopback <= next_dev[`BUD_DEV_LOOP];
      alt_double_buffer_select <= next_dev[`BUD_DEV_DBLBUF];
      lower_tx_idle_highz <= next_dev[`BUD_DEV_LHIZ];
      upper_tx_idle_highz <= next_dev[`BUD_DEV_UHIZ];
      dev_rsvd9 <= next_dev[`BUD_DEV_RSVD9];
      emergency_discharge_enable <= next_dev[`BUD_DEV_EMG];
      hv_pump_disable <= next_dev[`BUD_DEV_HVCP];
    end
  end

  // cell enable write-through
  // The owner latches the pulse one edge later; fwd_cell covers that gap for reads.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cell_meas_enable_wr <= 1'b0;
      cell_meas_enable_wdata <= 12'h000;
      fwd_cell <= 1'b0;
    end else if (ce) begin
      cell_meas_enable_wr <= wr_go && wr_sel == BUD_SEL_DIAG;
      fwd_cell <= wr_go && wr_sel == BUD_SEL_DIAG;
      if (wr_go && wr_sel == BUD_SEL_DIAG) begin
        cell_meas_enable_wdata <= next_cell;
      end
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    rd_word = `BUD_RST_WORD;
    unique case (decode_sel(haddr))
      BUD_SEL_NONE: begin
        rd_word = `BUD_RST_WORD;
      end
      BUD_SEL_BAL: begin
        rd_word = {4'h0, next_bal};
      end
      BUD_SEL_DEV: begin
        rd_word = next_dev;
      end
      BUD_SEL_DIAG: begin
        rd_word = 16'h0000;
        rd_word[`BUD_DIAG_ALT] = alt_mux_select;
        rd_word[`BUD_DIAG_POL] = polarity;
        rd_word[`BUD_DIAG_CELL_MSB:`BUD_DIAG_CELL_LSB] = next_cell;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= `BUD_RST_BUS;
    end else if (ce && addr_take && !hwrite) begin
      hrdata <= {16'h0000, rd_word};
    end
  end

  // Zero wait states; unmapped addresses read zero and ignore writes, always OKAY.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // UART pin drivers
  // lower idle level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_tx_pin_out <= 1'b0;
      lower_tx_pin_oe <= 1'b0;
    end else if (ce) begin
      lower_tx_pin_out <= lower_tx_busy & lower_tx_data;
      lower_tx_pin_oe <= lower_tx_busy | ~lower_tx_idle_highz;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_tx_pin_out <= 1'b0;
      upper_tx_pin_oe <= 1'b0;
    end else if (ce) begin
      upper_tx_pin_out <= upper_tx_busy & upper_tx_data;
      upper_tx_pin_oe <= upper_tx_busy | ~upper_tx_idle_highz;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
    end else if (ce) begin
      rx_s1 <= upper_rx_pin_in;
      rx_s2 <= rx_s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_rx_data <= 1'b0;
    end else if (ce) begin
      upper_rx_data <= upper_port_loopback ? (upper_tx_busy & upper_tx_data) : rx_s2;
    end
  end

  // ==========================================================
  // Emergency discharge counter
  // counter runs in mode
  bud_dchg_counter #(
    .TICK_CYCLES(DCHG_TICKS)
  ) u_dchg (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(emergency_discharge_enable),
    .count(discharge_counter)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic rd_bal_q;
  logic rd_diag_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_bal_q <= 1'b0;
      rd_diag_q <= 1'b0;
    end else begin
      rd_bal_q <= ce && addr_take && !hwrite && decode_sel(haddr) == BUD_SEL_BAL;
      rd_diag_q <= ce && addr_take && !hwrite && decode_sel(haddr) == BUD_SEL_DIAG;
    end
  end

  bal_write_a: assert property (ce && wr_go && wr_sel == BUD_SEL_BAL |=>
    balance_switch_enable == $past(hwdata[11:0]))
    else $error("balance enables not written");
  reserved_zero_a: assert property (rd_bal_q |-> hrdata[15:12] == 4'h0)
    else $error("reserved balance bits not zero");
  loopback_route_a: assert property (ce && upper_port_loopback ##1 ce |->
    upper_rx_data == $past(upper_tx_busy & upper_tx_data))
    else $error("loopback not routed");
  dblbuf_store_a: assert property (ce && wr_go && wr_sel == BUD_SEL_DEV |=>
    alt_double_buffer_select == $past(hwdata[12]) && dev_rsvd9 == $past(hwdata[9]))
    else $error("config bits not stored");
  lower_idle_a: assert property (ce && !lower_tx_busy && !lower_tx_idle_highz |=>
    lower_tx_pin_oe && !lower_tx_pin_out)
    else $error("lower idle not driven low");
  upper_idle_a: assert property (ce && !upper_tx_busy && upper_tx_idle_highz |=>
    !upper_tx_pin_oe)
    else $error("upper idle not released");
  emg_counter_a: assert property (ce && !emergency_discharge_enable ##1 ce |=>
    discharge_counter == 4'h0)
    else $error("counter runs outside mode");
  pump_write_a: assert property (ce && wr_go && wr_sel == BUD_SEL_DEV |=>
    hv_pump_disable == $past(hwdata[0]) && emergency_discharge_enable == $past(hwdata[8]))
    else $error("pump or discharge bit not written");
  mirror_read_a: assert property (rd_diag_q |-> hrdata[13] == $past(alt_mux_select) &&
    hrdata[12] == $past(polarity) && hrdata[15:14] == 2'b00)
    else $error("mirror bits wrong");
  cell_write_a: assert property (ce && wr_go && wr_sel == BUD_SEL_DIAG |=>
    cell_meas_enable_wr && cell_meas_enable_wdata == $past(hwdata[11:0]))
    else $error("cell enable write lost");

  loopback_c: cover property (ce && upper_port_loopback && upper_tx_busy);
  counter_wrap_c: cover property (discharge_counter == 4'hf ##[1:300] discharge_counter == 4'h0);
  diag_write_c: cover property (cell_meas_enable_wr);
  ce_hold_c: cover property (!ce && emergency_discharge_enable);
  reserved_bit_c: cover property (ce && wr_go && wr_sel == BUD_SEL_DEV && hwdata[9]);

endmodule : bud_regs

// File: inc/bud_cfg.svh
`ifndef BUD_CFG_SVH
`define BUD_CFG_SVH

// ==========================================================
// Register indices; the byte address is four times the index.
`define BUD_IDX_BAL 8'h1a
`define BUD_IDX_DEV 8'h1b
`define BUD_IDX_DIAG 8'h1c

// ==========================================================
// Field positions.
`define BUD_BAL_EN_MSB 11
`define BUD_BAL_RSVD_MSB 15
`define BUD_BAL_RSVD_LSB 12
`define BUD_DEV_LOOP 15
`define BUD_DEV_DBLBUF 12
`define BUD_DEV_LHIZ 11
`define BUD_DEV_UHIZ 10
`define BUD_DEV_RSVD9 9
`define BUD_DEV_EMG 8
`define BUD_DEV_HVCP 0
`define BUD_DIAG_ALT 13
`define BUD_DIAG_POL 12
`define BUD_DIAG_CELL_MSB 11
`define BUD_DIAG_CELL_LSB 0

// ==========================================================
// Reset values.
`define BUD_RST_WORD 16'h0000
`define BUD_RST_BUS 32'h0000_0000

// ==========================================================
// Timing: clock rate and the discharge counter rate, both in hertz.
`define BUD_CLK_HZ 32'h0098_9680
`define BUD_DCHG_HZ 32'h0000_0002
`define BUD_DCHG_TICKS (`BUD_CLK_HZ / `BUD_DCHG_HZ)

`endif

// File: inc/bud_pkg.sv
package bud_pkg;

  // Register select, one-hot.
  typedef enum logic [3:0] {
    BUD_SEL_NONE = 4'b0001,
    BUD_SEL_BAL = 4'b0010,
    BUD_SEL_DEV = 4'b0100,
    BUD_SEL_DIAG = 4'b1000
  } bud_sel_t;

  typedef logic [11:0] bud_cells_t;

endpackage : bud_pkg

// File: hdl/bud_dchg_counter.sv
`include "bud_cfg.svh"

module bud_dchg_counter #(
  parameter int unsigned TICK_CYCLES = `BUD_DCHG_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  output logic [3:0] count
);

  localparam int unsigned PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] pre;

  // A prescaler shorter than two cycles cannot make a tick, so refuse it at elaboration.
  if (TICK_CYCLES < 2) begin : g_bad_ticks
    $error("TICK_CYCLES must be at least 2");
  end

  // ==========================================================
  // Prescaler and counter
  // The counter is held at zero outside the mode so each run starts fresh.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
    end else if (ce) begin
      if (!run || pre == PRE_LAST) begin
        pre <= '0;
      end else begin
        pre <= pre + PW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 4'h0;
    end else if (ce) begin
      if (!run) begin
        count <= 4'h0;
      end else if (pre == PRE_LAST) begin
        count <= count + 4'h1;
      end
    end
  end

endmodule : bud_dchg_counter

// File: test/tb_top.sv
`include "bud_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned TICKS = 8;
  localparam logic [31:0] A_BAL = 32'(`BUD_IDX_BAL) * 4;
  localparam logic [31:0] A_DEV = 32'(`BUD_IDX_DEV) * 4;
  localparam logic [31:0] A_DIAG = 32'(`BUD_IDX_DIAG) * 4;

  logic clk, rst, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [11:0] balance_switch_enable, cell_meas_enable, cell_meas_enable_wdata;
  logic [3:0] discharge_counter, v;
  logic upper_port_loopback, alt_double_buffer_select, lower_tx_idle_highz, upper_tx_idle_highz;
  logic emergency_discharge_enable, hv_pump_disable, alt_mux_select, polarity, cell_meas_enable_wr;
  logic lower_tx_data, lower_tx_busy, lower_tx_pin_out, lower_tx_pin_oe;
  logic upper_tx_data, upper_tx_busy, upper_tx_pin_out, upper_tx_pin_oe, upper_rx_pin_in, upper_rx_data;
  int fails, n_checks, cyc, n_wr;
  logic [15:0] pv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0c00, 16'h0c00, 16'h0800};
  logic [3:0] pd [6] = '{4'b0000, 4'b1111, 4'b1010, 4'b0000, 4'b1111, 4'b0000};
  logic [3:0] pe [6] = '{4'b0101, 4'b1111, 4'b0101, 4'b0000, 4'b1111, 4'b0001};
  int db [7] = '{15, 12, 11, 10, 9, 8, 0};

  bud_regs #(.DCHG_TICKS(TICKS)) u_dut (
    .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .balance_switch_enable(balance_switch_enable), .upper_port_loopback(upper_port_loopback),
    .alt_double_buffer_select(alt_double_buffer_select), .lower_tx_idle_highz(lower_tx_idle_highz),
    .upper_tx_idle_highz(upper_tx_idle_highz), .emergency_discharge_enable(emergency_discharge_enable),
    .hv_pump_disable(hv_pump_disable), .discharge_counter(discharge_counter), .alt_mux_select(alt_mux_select),
    .polarity(polarity), .cell_meas_enable(cell_meas_enable), .cell_meas_enable_wr(cell_meas_enable_wr),
    .cell_meas_enable_wdata(cell_meas_enable_wdata), .lower_tx_data(lower_tx_data),
    .lower_tx_busy(lower_tx_busy), .lower_tx_pin_out(lower_tx_pin_out), .lower_tx_pin_oe(lower_tx_pin_oe),
    .upper_tx_data(upper_tx_data), .upper_tx_busy(upper_tx_busy), .upper_tx_pin_out(upper_tx_pin_out),
    .upper_tx_pin_oe(upper_tx_pin_oe), .upper_rx_pin_in(upper_rx_pin_in), .upper_rx_data(upper_rx_data)
  );

  // ==========================================================
  // Clock, timeout and the owner of the cell enables.
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  // The owner register loads the mirrored cell enables on the write pulse.
  always @(posedge clk) begin
    if (cell_meas_enable_wr === 1'b1) begin
      cell_meas_enable <= cell_meas_enable_wdata;
      n_wr <= n_wr + 1;
    end
  end

  // ==========================================================
  // Bus cycles and comparisons.
  task automatic conclude();
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000, "hresp");
    #1;
  endtask : bus

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk(r, exp, msg);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // ==========================================================
  // Main sequence.
  initial begin
    clk = 0; rst = 1; ce = 1; hsel = 1; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    alt_mux_select = 0; polarity = 0; cell_meas_enable = 0; upper_rx_pin_in = 0;
    lower_tx_data = 0; lower_tx_busy = 0; upper_tx_data = 0; upper_tx_busy = 0;
    fails = 0; n_checks = 0; cyc = 0; n_wr = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    rd_chk(A_BAL, 32'h0000_0000, "bal reset");
    rd_chk(A_DEV, 32'h0000_0000, "dev reset");
    rd_chk(A_DIAG, 32'h0000_0000, "diag reset");
    chk(32'({balance_switch_enable, upper_port_loopback, emergency_discharge_enable, hv_pump_disable}), 0, "outs");
    for (int n = 0; n < 12; n++) begin
      bus(A_BAL, 1'b1, 32'hffff_f000 | (32'h1 << n), d);
      chk(32'(balance_switch_enable), 32'h1 << n, "switch out");
      rd_chk(A_BAL, 32'h1 << n, "bal read");
    end
    bus(A_DEV, 1'b1, 32'h0000_ffff, d);
    rd_chk(A_DEV, 32'h0000_9f01, "dev all");
    for (int i = 0; i < 7; i++) begin
      bus(A_DEV, 1'b1, 32'h1 << db[i], d);
      rd_chk(A_DEV, 32'h1 << db[i], "dev bit");
      chk(32'({upper_port_loopback, alt_double_buffer_select, lower_tx_idle_highz, upper_tx_idle_highz,
               emergency_discharge_enable, hv_pump_disable}),
          32'({db[i] == 15, db[i] == 12, db[i] == 11, db[i] == 10, db[i] == 8, db[i] == 0}), "dev out");
    end
    for (int i = 0; i < 6; i++) begin
      bus(A_DEV, 1'b1, 32'(pv[i]), d);
      @(posedge clk);
      {lower_tx_busy, lower_tx_data, upper_tx_busy, upper_tx_data} <= pd[i];
      settle(2);
      chk(32'({lower_tx_pin_out, lower_tx_pin_oe, upper_tx_pin_out, upper_tx_pin_oe}), 32'(pe[i]), "pins");
    end
    bus(A_DEV, 1'b1, 32'h0000_8000, d);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      upper_tx_busy <= 1'b1;
      upper_tx_data <= i[0];
      upper_rx_pin_in <= ~i[0];
      settle(6);
      chk(32'(upper_rx_data), 32'(i[0]), "loopback");
      chk(32'(upper_tx_pin_oe), 32'h0000_0001, "loop drive");
    end
    bus(A_DEV, 1'b1, 32'h0000_0000, d);
    settle(6);
    chk(32'(upper_rx_data), 32'h0000_0000, "no loopback");
    bus(A_DEV, 1'b1, 32'h0000_0100, d);
    for (int k = 0; k < 17; k++) begin
      v = discharge_counter;
      settle(TICKS);
      chk(32'(discharge_counter), 32'(4'(v + 4'h1)), "dchg count");
    end
    @(posedge clk);
    ce <= 1'b0;
    settle(1);
    v = discharge_counter;
    settle(3 * TICKS);
    chk(32'(discharge_counter), 32'(v), "ce freeze");
    @(posedge clk);
    ce <= 1'b1;
    bus(A_DEV, 1'b1, 32'h0000_0000, d);
    settle(2);
    chk(32'(discharge_counter), 32'h0000_0000, "dchg off");
    @(posedge clk);
    alt_mux_select <= 1'b1;
    polarity <= 1'b1;
    cell_meas_enable <= 12'ha55;
    rd_chk(A_DIAG, 32'h0000_3a55, "diag mirror hi");
    @(posedge clk);
    alt_mux_select <= 1'b0;
    polarity <= 1'b0;
    cell_meas_enable <= 12'h255;
    rd_chk(A_DIAG, 32'h0000_0255, "diag mirror lo");
    bus(A_DIAG, 1'b1, 32'h0000_2b46, d);
    settle(2);
    chk(32'(n_wr), 32'h0000_0001, "cell pulse");
    chk(32'(cell_meas_enable), 32'h0000_0b46, "cell data");
    rd_chk(A_DIAG, 32'h0000_0b46, "diag after write");
    bus(32'h0000_0074, 1'b1, 32'h0000_ffff, d);
    rd_chk(32'h0000_0074, 32'h0000_0000, "unmapped");
    rd_chk(A_BAL, 32'h0000_0800, "bal kept");
    conclude();
  end
endmodule : tb_top
